// [src/irq_ctrl_pkg.sv]
// Constants, register map and state types of the reset-state and
// interrupt control block; shared by its design files.
package irq_ctrl_pkg;
   localparam int PC_W = 13;
   localparam int ADDR_W = 8;
   localparam int PERI_N = 6;
   localparam int EVT_W = 3;

   // Register byte offsets on the APB side
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PFLAG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PEN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PCAUSE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_OPT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_TMR = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PC = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_EVT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EMASK = 8'h24;

   // Field positions of irq_control_reg
   localparam int GIE_BIT = 7;
   localparam int PGE_BIT = 6;
   localparam int TMR_FLAG = 2;
   localparam int EXT_FLAG = 1;
   localparam int PORT_FLAG = 0;
   // Status register cause bits
   localparam int TO_BIT = 4;
   localparam int PD_BIT = 3;
   // Power cause register bits (active low causes); EDGE_SEL_BIT is in the option register
   localparam int PORN_BIT = 1;
   localparam int BORN_BIT = 0;
   localparam int EDGE_SEL_BIT = 6;
   // Event status bits
   localparam int EV_VECTOR = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_RESET = 2;

   localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
   localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;
   localparam logic [7:0] OPT_RST = 8'hff;
   localparam logic [7:0] TMR_TOP = 8'hff;
   localparam logic [1:0] Q_LAST = 2'h3;
   // Instruction boundaries waited after the first one seeing a request
   localparam logic [1:0] LAT_WAIT = 2'h2;
   // Most clocks a ready request may wait for its vector
   localparam logic [3:0] REQ_AGE_MAX = 4'hc;

   typedef enum logic {
      RUNNING = 1'b0,
      SLEEPING = 1'b1
   } run_state_e;
endpackage

// [src/sync3_level.sv]
// Three-flop synchroniser for a pin level; the output changes only
// once the second and third flops agree.
// Assumes one clock and a synchronous-release active-low reset.
`timescale 1ns/1ps
module sync3_level #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i, // Block clock
   input wire logic rst_n_i, // Active-low reset
   input wire logic async_i, // Pin from outside
   output logic level_o // Filtered level
);
   typedef struct packed {
      logic [2:0] ff;
      logic lvl;
   } sync_s;

   sync_s st_r;
   sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ff = {st_r.ff[1:0], async_i};
      if (st_r.ff[1] == st_r.ff[2]) begin
         st_nxt.lvl = st_r.ff[2];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= {{3{RST_VAL}}, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Agreement passes straight through, saving a clock of latency
   assign level_o = (st_r.ff[1] == st_r.ff[2]) ? st_r.ff[2] : st_r.lvl;
endmodule

// [src/instr_phase_div.sv]
// Quarter-phase counter: four clocks make one instruction cycle.
// Assumes the block clock and reset of the top module.
`timescale 1ns/1ps
module instr_phase_div
   import irq_ctrl_pkg::*;
(
   input wire logic clk_i, // Block clock
   input wire logic rst_n_i, // Active-low reset
   output logic tick_o // Last quarter of a cycle
);
   typedef struct packed {
      logic [1:0] q;
   } div_s;

   div_s st_r;
   div_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.q = 2'(st_r.q + 2'h1);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_o = (st_r.q == Q_LAST);
endmodule

// [src/reset_state_and_interrupt_control.sv]
// Interrupt control and reset-state logic with an APB register slave.
// Assumes the core, port logic, brown-out detector and watchdog share
// ref_clk_i; the two pins arrive asynchronously.
`timescale 1ns/1ps
module reset_state_and_interrupt_control
   import irq_ctrl_pkg::*;
(
   input wire logic ref_clk_i, // 20 MHz clock
   input wire logic reset_n_i, // Async power-on reset
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB write
   input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr_i, // APB address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error
   input wire logic external_irq_pin_i, // External interrupt pin
   input wire logic external_reset_pin_n_i, // External reset pin
   input wire logic port_change_i, // Port change pulse
   input wire logic [irq_ctrl_pkg::PERI_N-1:0] peri_evt_i, // Peri events
   input wire logic timer_tick_i, // Timer count pulse
   input wire logic brown_out_i, // Brown-out reset pulse
   input wire logic watchdog_timeout_i, // Watchdog time-out pulse
   input wire logic sleep_i, // Sleep instruction pulse
   input wire logic return_from_irq_instr_i, // Return pulse
   input wire logic pc_load_i, // Core branch at boundary
   input wire logic [irq_ctrl_pkg::PC_W-1:0] pc_load_val_i, // Target
   output logic [irq_ctrl_pkg::PC_W-1:0] pc_o, // Program counter
   output logic push_o, // Push return address
   output logic [irq_ctrl_pkg::PC_W-1:0] ret_addr_o, // Address pushed
   output logic asleep_o, // Core is asleep
   output logic irq_o // Event interrupt
);
   import irq_ctrl_pkg::*;

   typedef struct packed {
      logic por_pend;
      logic [7:0] ctrl;
      logic [PERI_N-1:0] pflag;
      logic [PERI_N-1:0] pen;
      logic [7:0] stat;
      logic [1:0] pcause;
      logic [7:0] opt;
      logic [7:0] tmr;
      logic [PC_W-1:0] pc;
      run_state_e mode;
      logic [1:0] lat;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] emask;
      logic [31:0] prdata;
      logic ext_prev;
      logic external_reset_pin_prev;
      logic push;
      logic [PC_W-1:0] ret;
      logic [3:0] req_age;
   } ctl_s;

   ctl_s st_r;
   ctl_s st_nxt;
   logic [1:0] rsync_r;
   logic rst_n;
   logic tick;
   logic ext_lvl;
   logic external_reset_pin_lvl;
   logic wr;
   logic rd_acc;
   logic setup;
   logic mapped;
   logic en_any;
   logic req;
   logic pin_edge;
   logic external_reset_pin_fall;
   logic wdt_rst;
   logic rst_evt;
   logic [31:0] rdv;

   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsync_r <= 2'h0;
      end else begin
         rsync_r <= {rsync_r[0], 1'b1};
      end
   end
   assign rst_n = rsync_r[1];

   instr_phase_div u_div (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .tick_o(tick)
   );

   sync3_level #(.RST_VAL(1'b0)) u_ext_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .async_i(external_irq_pin_i),
      .level_o(ext_lvl)
   );

   sync3_level #(.RST_VAL(1'b1)) u_external_reset_pin_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .async_i(external_reset_pin_n_i),
      .level_o(external_reset_pin_lvl)
   );

   assign setup = psel_i & ~penable_i;
   assign wr = psel_i & penable_i & pwrite_i;
   assign rd_acc = psel_i & penable_i & ~pwrite_i;
   assign mapped = (paddr_i <= OFS_EMASK) && (paddr_i[1:0] == 2'h0);

   // Core flags pair with enables 5:3; peripherals need the group bit
   assign en_any = |(st_r.ctrl[2:0] & st_r.ctrl[5:3])
      | (st_r.ctrl[PGE_BIT] & |(st_r.pflag & st_r.pen));
   assign req = st_r.ctrl[GIE_BIT] & en_any;

   assign pin_edge = st_r.opt[EDGE_SEL_BIT]
      ? (ext_lvl & ~st_r.ext_prev)
      : (~ext_lvl & st_r.ext_prev);
   assign external_reset_pin_fall = ~external_reset_pin_lvl & st_r.external_reset_pin_prev;
   assign wdt_rst = watchdog_timeout_i & (st_r.mode == RUNNING);
   assign rst_evt = st_r.por_pend | brown_out_i | external_reset_pin_fall | wdt_rst;

   always_comb begin
      rdv = 32'h0;
      case (paddr_i)
         OFS_CTRL: rdv = {24'h0, st_r.ctrl};
         OFS_PFLAG: rdv = {26'h0, st_r.pflag};
         OFS_PEN: rdv = {26'h0, st_r.pen};
         OFS_STAT: rdv = {24'h0, st_r.stat};
         OFS_PCAUSE: rdv = {30'h0, st_r.pcause};
         OFS_OPT: rdv = {24'h0, st_r.opt};
         OFS_TMR: rdv = {24'h0, st_r.tmr};
         OFS_PC: rdv = {19'h0, st_r.pc};
         OFS_EVT: rdv = {29'h0, st_r.evt};
         OFS_EMASK: rdv = {29'h0, st_r.emask};
         default: rdv = 32'h0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.por_pend = 1'b0;
      st_nxt.push = 1'b0;
      st_nxt.ext_prev = ext_lvl;
      st_nxt.external_reset_pin_prev = external_reset_pin_lvl;
      // Clocks a request has waited; watched by the latency check
      st_nxt.req_age = (req && st_r.mode == RUNNING && external_reset_pin_lvl)
         ? 4'(st_r.req_age + 4'h1) : 4'h0;
      if (setup) begin
         st_nxt.prdata = rdv;
      end
      if (rd_acc && paddr_i == OFS_EVT) begin
         st_nxt.evt = '0;
      end
      if (wr) begin
         case (paddr_i)
            OFS_CTRL: st_nxt.ctrl = pwdata_i[7:0];
            OFS_PFLAG: st_nxt.pflag = pwdata_i[PERI_N-1:0];
            OFS_PEN: st_nxt.pen = pwdata_i[PERI_N-1:0];
            OFS_STAT: st_nxt.stat = {pwdata_i[7:5], st_r.stat[4:3],
                                     pwdata_i[2:0]};
            OFS_PCAUSE: st_nxt.pcause = pwdata_i[1:0];
            OFS_OPT: st_nxt.opt = pwdata_i[7:0];
            OFS_TMR: st_nxt.tmr = pwdata_i[7:0];
            OFS_EMASK: st_nxt.emask = pwdata_i[EVT_W-1:0];
            default: ;
         endcase
      end
      // Hardware sets land after the write so no flag event is lost; a timer tick during a TMR write is dropped
      if (timer_tick_i && !(wr && paddr_i == OFS_TMR)) begin
         st_nxt.tmr = 8'(st_r.tmr + 8'h01);
         if (st_r.tmr == TMR_TOP) begin
            st_nxt.ctrl[TMR_FLAG] = 1'b1;
         end
      end
      if (pin_edge) begin
         st_nxt.ctrl[EXT_FLAG] = 1'b1;
      end
      if (port_change_i) begin
         st_nxt.ctrl[PORT_FLAG] = 1'b1;
      end
      st_nxt.pflag = st_nxt.pflag | peri_evt_i;
      if (return_from_irq_instr_i) begin
         st_nxt.ctrl[GIE_BIT] = 1'b1;
      end
      case (st_r.mode)
         RUNNING: begin
            if (sleep_i) begin
               st_nxt.mode = SLEEPING;
               st_nxt.stat[TO_BIT] = 1'b1;
               st_nxt.stat[PD_BIT] = 1'b0;
            end else if (tick && external_reset_pin_lvl) begin
               // Flags stay set: a still-set flag retriggers
               if (req && st_r.lat == LAT_WAIT) begin
                  st_nxt.ctrl[GIE_BIT] = 1'b0;
                  st_nxt.push = 1'b1;
                  st_nxt.ret = st_r.pc;
                  st_nxt.pc = VECTOR_PC;
                  st_nxt.lat = 2'h0;
                  st_nxt.evt[EV_VECTOR] = 1'b1;
               end else begin
                  // Fixed boundary count gives the same latency for
                  // one- and two-cycle instructions
                  st_nxt.lat = req ? 2'(st_r.lat + 2'h1) : 2'h0;
                  st_nxt.pc = pc_load_i ? pc_load_val_i
                                        : PC_W'(st_r.pc + 13'h1);
               end
            end
         end
         SLEEPING: begin
            if (watchdog_timeout_i) begin
               st_nxt.mode = RUNNING;
               st_nxt.stat[TO_BIT] = 1'b0;
               st_nxt.stat[PD_BIT] = 1'b0;
               st_nxt.pc = PC_W'(st_r.pc + 13'h1);
               st_nxt.evt[EV_WAKE] = 1'b1;
            end else if (en_any) begin
               st_nxt.mode = RUNNING;
               st_nxt.stat[TO_BIT] = 1'b1;
               st_nxt.stat[PD_BIT] = 1'b0;
               st_nxt.evt[EV_WAKE] = 1'b1;
               if (st_r.ctrl[GIE_BIT]) begin
                  st_nxt.ctrl[GIE_BIT] = 1'b0;
                  st_nxt.push = 1'b1;
                  st_nxt.ret = PC_W'(st_r.pc + 13'h1);
                  st_nxt.pc = VECTOR_PC;
                  st_nxt.evt[EV_VECTOR] = 1'b1;
               end else begin
                  st_nxt.pc = PC_W'(st_r.pc + 13'h1);
               end
            end
         end
         default: st_nxt.mode = RUNNING;
      endcase
      // Resets override pc, ctrl, pflag, pen, opt, mode and push set above; por beats brown-out
      if (rst_evt) begin
         st_nxt.pc = RESET_PC;
         st_nxt.ctrl = {7'h00, st_r.ctrl[PORT_FLAG]};
         st_nxt.pflag = '0;
         st_nxt.pen = '0;
         st_nxt.opt = OPT_RST;
         st_nxt.mode = RUNNING;
         st_nxt.lat = 2'h0;
         st_nxt.push = 1'b0;
         st_nxt.stat[7:5] = 3'h0;
         if (!st_r.por_pend) begin
            st_nxt.evt[EV_RESET] = 1'b1;
         end
         if (st_r.por_pend) begin
            st_nxt.stat[4:3] = 2'b11;
            st_nxt.pcause[PORN_BIT] = 1'b0;
         end else if (brown_out_i) begin
            st_nxt.stat[4:3] = 2'b11;
            st_nxt.pcause[BORN_BIT] = 1'b0;
         end else if (external_reset_pin_fall) begin
            if (st_r.mode == SLEEPING) begin
               st_nxt.stat[4:3] = 2'b10;
            end
         end else begin
            st_nxt.stat[4:3] = 2'b01;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.por_pend <= 1'b1;
         st_r.external_reset_pin_prev <= 1'b1;
         st_r.opt <= OPT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata_o = st_r.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;
   assign pc_o = st_r.pc;
   assign push_o = st_r.push;
   assign ret_addr_o = st_r.ret;
   assign asleep_o = (st_r.mode == SLEEPING);
   // Level output: high while an event bit enabled in EMASK is set; a read of the event register clears the bits
   assign irq_o = |(st_r.evt & st_r.emask);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   gie_blocks_a: assert property (
      !st_r.ctrl[GIE_BIT] |=> !push_o)
      else $error("Vector taken with global enable clear");

   vector_now_a: assert property (
      tick && req && st_r.lat == LAT_WAIT && external_reset_pin_lvl && !sleep_i
      && st_r.mode == RUNNING && !rst_evt |=> push_o)
      else $error("Ready request did not vector");

   flag_sets_a: assert property (
      peri_evt_i[0] && !rst_evt |=> st_r.pflag[0])
      else $error("Peripheral flag not set by its event");

   reset_gie_a: assert property (
      rst_evt |=> !st_r.ctrl[GIE_BIT] && pc_o == RESET_PC)
      else $error("Reset left global enable or pc");

   ret_gie_a: assert property (
      return_from_irq_instr_i && !rst_evt && st_r.mode == RUNNING
      && !(tick && req) |=> st_r.ctrl[GIE_BIT])
      else $error("Return did not set global enable");

   vector_pc_a: assert property (
      push_o |-> pc_o == VECTOR_PC && !st_r.ctrl[GIE_BIT])
      else $error("Vector without pc 0004h or enable clear");

   req_latency_a: assert property (
      st_r.req_age <= REQ_AGE_MAX)
      else $error("Pending request waited too long to vector");

   timer_wrap_a: assert property (
      timer_tick_i && st_r.tmr == TMR_TOP && !wr && !rst_evt
      |=> st_r.ctrl[TMR_FLAG] && st_r.tmr == 8'h00)
      else $error("Timer wrap did not set its flag");

   por_state_a: assert property (
      st_r.por_pend |=> st_r.stat[7:3] == 5'b00011
      && !st_r.pcause[PORN_BIT])
      else $error("Power-on status or cause wrong");

   wdt_wake_a: assert property (
      st_r.mode == SLEEPING && watchdog_timeout_i && !rst_evt
      |=> pc_o == PC_W'($past(st_r.pc) + 13'h1) && st_r.stat[4:3] == 2'b00)
      else $error("Watchdog wake-up pc or status wrong");
endmodule

// [tb/cpu_core_model.sv]
// Stand-in for the CPU core: return-address stack, return instruction.
// Assumes the block clock; the bench commands each return.
`timescale 1ns/1ps
module cpu_core_model
   import irq_ctrl_pkg::*;
(
   input wire logic clk_i, // Block clock
   input wire logic rst_n_i, // Active-low reset
   input wire logic push_i, // Push strobe
   input wire logic [irq_ctrl_pkg::PC_W-1:0] ret_addr_i, // Pushed addr
   input wire logic ret_cmd_i, // Bench asks for a return
   output logic ret_o, // Return instruction pulse
   output logic [3:0] depth_o, // Entries stacked
   output logic [irq_ctrl_pkg::PC_W-1:0] top_o // Last address pushed
);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ret_o <= 1'b0;
         depth_o <= 4'h0;
         top_o <= '0;
      end else begin
         // No return without a stacked address, as software would
         ret_o <= ret_cmd_i && depth_o != 4'h0;
         if (push_i) begin
            depth_o <= depth_o + 4'h1;
            top_o <= ret_addr_i;
         end else if (ret_o) begin
            depth_o <= depth_o - 4'h1;
         end
      end
   end
endmodule

// [tb/reset_state_and_interrupt_control_test.sv]
// Self-checking bench for the interrupt and reset-state block.
// Assumes the design package and the core stand-in model.
`timescale 1ns/1ps
module reset_state_and_interrupt_control_test;
   import irq_ctrl_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pin = 1'b0, xrst_n = 1'b1;
   logic perr, pready, eseen, ret, push, asleep, irq;
   logic ld = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [5:0] ev = '0;
   logic [PERI_N-1:0] peri = '0;
   logic [PC_W-1:0] pc, raddr, s, ldv = '0;
   logic [3:0] depth;
   logic [7:0] e, p, g;
   int error_cnt = 0, checks_done = 0, n;
   logic [31:0] est [3] = '{32'h10, 32'h08, 32'h18};
   logic [31:0] epc [3] = '{32'h3, 32'h3, 32'h2};

   always #25 clk = ~clk;

   reset_state_and_interrupt_control uut (
      .ref_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
      .external_irq_pin_i(pin), .external_reset_pin_n_i(xrst_n),
      .port_change_i(ev[0]), .peri_evt_i(peri), .timer_tick_i(ev[1]),
      .brown_out_i(ev[2]), .watchdog_timeout_i(ev[3]), .sleep_i(ev[4]),
      .return_from_irq_instr_i(ret), .pc_load_i(ld),
      .pc_load_val_i(ldv), .pc_o(pc), .push_o(push), .ret_addr_o(raddr),
      .asleep_o(asleep), .irq_o(irq)
   );
   cpu_core_model core (
      .clk_i(clk), .rst_n_i(rst_n), .push_i(push), .ret_addr_i(raddr),
      .ret_cmd_i(ev[5]), .ret_o(ret), .depth_o(depth), .top_o()
   );

   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      eseen = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, x);
      bus(1'b0, a, '0);
      chk(nm, x, q & m);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask

   task automatic peri_pulse(input logic [5:0] v);
      @(posedge clk);
      peri <= v;
      @(posedge clk);
      peri <= '0;
   endtask

   // Push is a one-clock pulse, so look at every falling edge
   task automatic wait_push(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (push !== 1'b1 && n < lim);
   endtask

   task automatic wait_pc(input logic [PC_W-1:0] v, input string nm);
      for (int j = 0; j < 16 && pc !== v; j++) @(negedge clk);
      chk(nm, 32'(v), 32'(pc));
   endtask

   function automatic logic req(input logic [7:0] gp,
                                input logic [5:0] f, en);
      return gp[7] & gp[6] & |(f & en);
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      error_cnt++;
      summarize();
   end

   initial begin
      void'($urandom(61803));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rc("ctrl", OFS_CTRL, 32'hfe, 32'h0);
      rc("status", OFS_STAT, 32'hf8, 32'h18);
      rc("pcause", OFS_PCAUSE, 32'h2, 32'h0);
      rc("option", OFS_OPT, 32'hff, 32'hff);
      wr(OFS_STAT, 32'h0);
      rc("status ro", OFS_STAT, 32'h18, 32'h18);
      bus(1'b0, 8'h28, '0);
      chk("unmapped", 32'h1, 32'(eseen));
      bus(1'b1, 8'h06, 32'hff);
      chk("unaligned", 32'h1, 32'(eseen));
      $display("test reset_values done");
      p = 8'($urandom) | 8'h1;
      wr(OFS_TMR, 32'hff);
      pulse(0);
      pulse(1);
      pin <= 1'b1;
      peri_pulse(p[5:0]);
      repeat (12) @(posedge clk);
      rc("core flags", OFS_CTRL, 32'h7, 32'h7);
      rc("peri flags", OFS_PFLAG, 32'h3f, 32'(p[5:0]));
      rc("timer", OFS_TMR, 32'hff, 32'h0);
      chk("no push", 32'h0, 32'(depth));
      $display("test flags done");
      wr(OFS_EMASK, 32'h1);
      for (int i = 0; i < 10; i++) begin
         e = (i < 2) ? 8'h3f : 8'($urandom);
         p = (i < 2) ? 8'h3f : 8'($urandom);
         g = (i == 0) ? 8'hc0 : (i == 1) ? 8'h40 : 8'($urandom) & 8'hc0;
         wr(OFS_CTRL, 32'h0);
         wr(OFS_PFLAG, 32'h0);
         wr(OFS_PEN, 32'(e));
         peri_pulse(p[5:0]);
         wr(OFS_CTRL, 32'(g));
         wait_push(20);
         chk("push", 32'(req(g, p[5:0], e[5:0])), 32'(push));
         if (push === 1'b1) begin
            chk("vector", 32'(VECTOR_PC), 32'(pc));
            rc("gie off", OFS_CTRL, 32'h80, 32'h0);
            chk("irq set", 32'h1, 32'(irq));
            rc("event", OFS_EVT, 32'h1, 32'h1);
            @(negedge clk);
            chk("irq clear", 32'h0, 32'(irq));
            wr(OFS_PFLAG, 32'h0);
            pulse(5);
            repeat (2) @(posedge clk);
            rc("gie on", OFS_CTRL, 32'h80, 32'h80);
         end else begin
            chk("irq idle", 32'h0, 32'(irq));
         end
      end
      $display("test enables done");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_EMASK, 32'h0);
      wr(OFS_OPT, 32'hbf);
      wr(OFS_CTRL, 32'h90);
      @(posedge clk);
      pin <= 1'b0;
      wait_push(24);
      chk("pin push", 32'h1, 32'(push));
      chk("pin latency", 32'h1, 32'(n >= 12 && n <= 16));
      rc("flag kept", OFS_CTRL, 32'h2, 32'h2);
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFS_CTRL, 32'h0);
      @(posedge clk);
      pin <= 1'b1;
      repeat (12) @(posedge clk);
      rc("wrong edge", OFS_CTRL, 32'h2, 32'h0);
      $display("test pin done");
      pulse(4);
      repeat (4) @(negedge clk);
      chk("asleep", 32'h1, 32'(asleep));
      s = pc;
      pulse(3);
      wait_pc(s + 13'h1, "wdt wake pc");
      rc("wdt wake status", OFS_STAT, 32'h18, 32'h0);
      wr(OFS_CTRL, 32'h88);
      pulse(4);
      repeat (4) @(negedge clk);
      s = pc;
      pulse(0);
      wait_push(20);
      chk("wake vector", 32'(VECTOR_PC), 32'(pc));
      chk("wake ret", 32'(s + 13'h1), 32'(raddr));
      rc("irq wake status", OFS_STAT, 32'h18, 32'h10);
      @(posedge clk);
      ld <= 1'b1;
      ldv <= 13'($urandom);
      repeat (6) @(posedge clk);
      ld <= 1'b0;
      @(negedge clk);
      chk("branch pc", 32'(ldv), 32'(pc));
      $display("test sleep done");
      for (int k = 0; k < 3; k++) begin
         wr(OFS_PFLAG, 32'h0);
         wr(OFS_CTRL, 32'hc1);
         wr(OFS_PCAUSE, 32'h3);
         if (k == 0) begin
            @(posedge clk);
            xrst_n <= 1'b0;
         end else begin
            pulse(k == 1 ? 3 : 2);
         end
         wait_pc(RESET_PC, "reset pc");
         @(posedge clk);
         xrst_n <= 1'b1;
         repeat (4) @(posedge clk);
         rc("reset ctrl", OFS_CTRL, 32'hfe, 32'h0);
         if (k < 2) rc("ctrl bit0", OFS_CTRL, 32'h1, 32'h1);
         rc("reset status", OFS_STAT, 32'hf8, est[k]);
         rc("reset pcause", OFS_PCAUSE, 32'h3, epc[k]);
      end
      $display("test resets done");
      summarize();
   end
endmodule
